// ==== bvf_pkg.sv ====
// Constants and types for the V and F bit timing block
package bvf_pkg;
  localparam int          NUM_REGS       = 6;
  localparam logic [7:0]  ADDR_FIRST     = 8'he5;
  localparam logic [7:0]  ADDR_NTSC_VBEG = 8'he5;
  localparam logic [7:0]  ADDR_NTSC_VEND = 8'he6;
  localparam logic [7:0]  ADDR_NTSC_FTOG = 8'he7;
  localparam logic [7:0]  ADDR_PAL_VBEG  = 8'he8;
  localparam logic [7:0]  ADDR_PAL_VEND  = 8'he9;
  localparam logic [7:0]  ADDR_PAL_FTOG  = 8'hea;
  localparam logic [7:0]  ADDR_LAST      = 8'hea;
  // Field positions
  localparam int          COUNT_LSB      = 0;
  localparam int          COUNT_W        = 5;
  localparam int          POL_BIT        = 5;
  localparam int          EVEN_DLY_BIT   = 6;
  localparam int          ODD_DLY_BIT    = 7;
  // Reset values
  localparam logic [7:0]  RST_NTSC_VBEG  = 8'h05;
  localparam logic [7:0]  RST_NTSC_VEND  = 8'h04;
  localparam logic [7:0]  RST_NTSC_FTOG  = 8'h03;
  localparam logic [7:0]  RST_PAL_VBEG   = 8'h05;
  localparam logic [7:0]  RST_PAL_VEND   = 8'h14;
  localparam logic [7:0]  RST_PAL_FTOG   = 8'h03;
  // Slot order within one standard
  localparam int          SLOT_VBEG      = 0;
  localparam int          SLOT_VEND      = 1;
  localparam int          SLOT_FTOG      = 2;
  localparam int          PAL_BASE       = 3;
  localparam logic [5:0]  LINE_MAX       = 6'h3f;
  localparam logic [7:0]  UNMAPPED_RDATA = 8'h00;

  typedef struct packed {
    logic       odd_dly;
    logic       even_dly;
    logic       polarity;
    logic [4:0] count;
  } bvf_edge_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bvf_req_t;
endpackage

// ==== bvf_timing.sv ====
// V and F bit placement for the BT.656 output, NTSC and PAL
`timescale 1ns/100ps
module bvf_timing (
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic            ce,
  input  wire bvf_pkg::bvf_req_t reg_req,
  output logic [7:0]           reg_rdata,
  input  wire logic            line_strobe,
  input  wire logic            counter_rollover,
  input  wire logic            pal_mode,
  output logic                 vblank_bit,
  output logic                 field_bit,
  output logic [5:0]           internal_line_counter
);
  localparam logic [7:0] RST_VALS [bvf_pkg::NUM_REGS] = '{
    bvf_pkg::RST_NTSC_VBEG, bvf_pkg::RST_NTSC_VEND, bvf_pkg::RST_NTSC_FTOG,
    bvf_pkg::RST_PAL_VBEG,  bvf_pkg::RST_PAL_VEND,  bvf_pkg::RST_PAL_FTOG};

  logic [7:0]        regs_r [bvf_pkg::NUM_REGS];
  logic [7:0]        reg_rdata_r;
  logic [5:0]        line_r;
  logic [5:0]        line_nxt;
  logic              vblank_r;
  logic              field_r;
  logic              par_r;
  logic              par_now;
  logic [7:0]        offs;
  logic              in_map;
  logic [2:0]        base;
  bvf_pkg::bvf_edge_t cfg_beg;
  bvf_pkg::bvf_edge_t cfg_end;
  bvf_pkg::bvf_edge_t cfg_tog;
  logic [5:0]        eff_beg;
  logic [5:0]        eff_end;
  logic [5:0]        eff_tog;
  logic              hit_beg;
  logic              hit_end;
  logic              hit_tog;

  // Extra line taken from the delay bit of the current field
  function automatic logic [5:0] eff_line(input bvf_pkg::bvf_edge_t e, input logic odd);
    logic dly;
    dly = odd ? e.odd_dly : e.even_dly;
    eff_line = {1'b0, e.count} + {5'h00, dly};
  endfunction

  assign offs   = reg_req.addr - bvf_pkg::ADDR_FIRST;
  assign in_map = (reg_req.addr >= bvf_pkg::ADDR_FIRST) && (reg_req.addr <= bvf_pkg::ADDR_LAST);

  // Register slots, all eight bits stored as written
  genvar gi;
  generate
    for (gi = 0; gi < bvf_pkg::NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          regs_r[gi] <= RST_VALS[gi];
        end else if (ce && reg_req.wr && in_map && offs == 8'(gi)) begin
          // Bit 7 kept and steers the odd field delay
          regs_r[gi] <= reg_req.wdata;
        end
      end
    end
  endgenerate

  // Read port, unmapped addresses read zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else if (ce && reg_req.rd) begin
      if (in_map) begin
        reg_rdata_r <= regs_r[offs[2:0]];
      end else begin
        reg_rdata_r <= bvf_pkg::UNMAPPED_RDATA;
      end
    end
  end
  assign reg_rdata = reg_rdata_r;

  // Standard selection
  always_comb begin
    base    = pal_mode ? 3'(bvf_pkg::PAL_BASE) : 3'h0;
    cfg_beg = regs_r[base + 3'(bvf_pkg::SLOT_VBEG)];
    cfg_end = regs_r[base + 3'(bvf_pkg::SLOT_VEND)];
    cfg_tog = regs_r[base + 3'(bvf_pkg::SLOT_FTOG)];
  end

  // Effective lines with per-field delay
  assign eff_beg = eff_line(cfg_beg, par_now);
  assign eff_end = eff_line(cfg_end, par_now);
  assign eff_tog = eff_line(cfg_tog, par_now);

  // Line number after this strobe, saturating
  always_comb begin
    if (counter_rollover) begin
      line_nxt = 6'h00;
    end else if (line_r == bvf_pkg::LINE_MAX) begin
      line_nxt = line_r;
    end else begin
      line_nxt = line_r + 6'h01;
    end
  end

  assign hit_beg = line_strobe && (line_nxt == eff_beg);
  assign hit_end = line_strobe && (line_nxt == eff_end);
  assign hit_tog = line_strobe && (line_nxt == eff_tog);

  // Lines since rollover
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_r <= 6'h00;
    end else if (ce && line_strobe) begin
      line_r <= line_nxt;
    end
  end
  assign internal_line_counter = line_r;

  // V bit: rise at begin, fall at end; end wins on a tie
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vblank_r <= 1'b0;
    end else if (ce) begin
      if (hit_end) begin
        vblank_r <= 1'b0;
      end else if (hit_beg) begin
        vblank_r <= 1'b1;
      end
    end
  end
  assign vblank_bit = vblank_r;

  // F bit toggle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      field_r <= 1'b0;
    end else if (ce && hit_tog) begin
      field_r <= ~field_r;
    end
  end
  assign field_bit = field_r;

  // Field parity held from rollover, so F toggles once per field
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      par_r <= 1'b0;
    end else if (ce && line_strobe && counter_rollover) begin
      par_r <= field_r;
    end
  end
  assign par_now = (line_strobe && counter_rollover) ? field_r : par_r;

  // Checks
  AST_F_TOGGLES: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && hit_tog |=> field_bit != $past(field_bit))
    else $error("F bit did not toggle at its line");
  AST_F_STEADY: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(ce && hit_tog) |=> field_bit == $past(field_bit))
    else $error("F bit changed off its line");
  AST_F_DELAY: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && line_strobe && !par_now && cfg_tog.even_dly && line_nxt == {1'b0, cfg_tog.count}
    |=> field_bit == $past(field_bit))
    else $error("Even field delay ignored for F");
  AST_V_END_EVEN: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && hit_end && !par_now |=> !vblank_bit)
    else $error("V did not fall in even field");
  AST_V_END_ODD: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && hit_end && par_now |=> !vblank_bit)
    else $error("V did not fall in odd field");
  AST_V_BEGIN: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && hit_beg && !hit_end |=> vblank_bit)
    else $error("V did not rise at begin line");
  AST_V_BEG_DLY: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && line_strobe && par_now && cfg_beg.odd_dly && !vblank_r && !hit_end
    && line_nxt == {1'b0, cfg_beg.count} |=> !vblank_bit)
    else $error("Odd field delay ignored for V rise");
  AST_V_END_DLY: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && line_strobe && !par_now && cfg_end.even_dly && vblank_r && !hit_beg
    && line_nxt == {1'b0, cfg_end.count} |=> vblank_bit)
    else $error("Even field delay ignored for V fall");
  AST_V_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(ce && (hit_beg || hit_end)) |=> $stable(vblank_bit))
    else $error("V changed off its edges");
  AST_PAL_SEL: assert property (@(posedge core_clk) disable iff (sys_rst)
    pal_mode && ce && line_strobe
    && line_nxt == eff_line(regs_r[bvf_pkg::PAL_BASE + bvf_pkg::SLOT_FTOG], par_now)
    |=> field_bit != $past(field_bit))
    else $error("PAL toggle settings not selected");
  AST_NTSC_BEG: assert property (@(posedge core_clk) disable iff (sys_rst)
    !pal_mode && ce && line_strobe
    && line_nxt == eff_line(regs_r[bvf_pkg::SLOT_VBEG], par_now)
    && line_nxt != eff_line(regs_r[bvf_pkg::SLOT_VEND], par_now)
    |=> vblank_bit)
    else $error("NTSC begin settings not selected");
  AST_FREEZE: assert property (@(posedge core_clk) disable iff (sys_rst)
    !ce |=> $stable(vblank_bit) && $stable(field_bit) && $stable(line_r))
    else $error("State moved with clock enable low");
  AST_LINE_ROLL: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && line_strobe && counter_rollover |=> internal_line_counter == 6'h00)
    else $error("Line counter did not restart at rollover");
  AST_LINE_STEP: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && line_strobe && !counter_rollover && line_r != bvf_pkg::LINE_MAX
    |=> internal_line_counter == $past(line_r) + 6'h01)
    else $error("Line counter did not advance on a line");
  AST_PAR_LATCH: assert property (@(posedge core_clk) disable iff (sys_rst)
    ce && line_strobe && counter_rollover |=> par_r == $past(field_r))
    else $error("Field parity not taken at rollover");

  COV_V_PULSE: cover property (@(posedge core_clk) disable iff (sys_rst)
    ce && hit_beg ##[1:1000] ce && hit_end);
  COV_F_TOGGLE: cover property (@(posedge core_clk) disable iff (sys_rst) ce && hit_tog);
  COV_PAL_V: cover property (@(posedge core_clk) disable iff (sys_rst)
    pal_mode && ce && hit_beg);
  COV_DELAYED: cover property (@(posedge core_clk) disable iff (sys_rst)
    ce && hit_end && par_now && cfg_end.odd_dly);
  COV_F_DELAYED: cover property (@(posedge core_clk) disable iff (sys_rst)
    ce && hit_tog && !par_now && cfg_tog.even_dly);
endmodule

// ==== bvf_line_src.sv ====
// Line source model feeding line strobes and counter rollover
`timescale 1ns/100ps
module bvf_line_src #(
  parameter int LINE_LEN    = 3,
  parameter int FIELD_LINES = 26
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      line_strobe,
  output logic      counter_rollover
);
  int cyc_r;
  int line_r;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_r <= 0;
      line_r <= 0;
      line_strobe <= 1'b0;
      counter_rollover <= 1'b0;
    end else begin
      line_strobe <= run && cyc_r == 0;
      counter_rollover <= run && cyc_r == 0 && line_r == 0;
      if (run) begin
        cyc_r <= (cyc_r == LINE_LEN - 1) ? 0 : cyc_r + 1;
        if (cyc_r == 0) begin
          line_r <= (line_r == FIELD_LINES - 1) ? 0 : line_r + 1;
        end
      end
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the V and F bit timing block
`timescale 1ns/100ps
module tb;
  logic              core_clk, sys_rst, ce, run, pal_mode;
  bvf_pkg::bvf_req_t reg_req;
  logic [7:0]        reg_rdata, dly;
  logic              line_strobe, counter_rollover, vblank_bit, field_bit;
  logic [5:0]        internal_line_counter, exp_cnt, nl;
  logic [7:0]        regs [6];
  logic [7:0]        defs [6];
  logic              exp_v, exp_f, exp_p, pn;
  int                errors, compares;

  bvf_timing DUT (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .line_strobe(line_strobe), .counter_rollover(counter_rollover),
    .pal_mode(pal_mode), .vblank_bit(vblank_bit), .field_bit(field_bit),
    .internal_line_counter(internal_line_counter));
  bvf_line_src SRC (.core_clk(core_clk), .sys_rst(sys_rst), .run(run),
    .line_strobe(line_strobe), .counter_rollover(counter_rollover));

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    reg_req <= '0;
    if (ce && a >= bvf_pkg::ADDR_FIRST && a <= bvf_pkg::ADDR_LAST) begin
      regs[a - bvf_pkg::ADDR_FIRST] = d;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    reg_req <= '0;
    chk_byte("reg_rdata", e, reg_rdata);
  endtask
  task automatic run_lines(input int n);
    run = 1'b1;
    repeat (n * 3) @(negedge core_clk);
    run = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [5:0] eff(input int s);
    logic [7:0] r;
    r = regs[s + (pal_mode ? 3 : 0)];
    return {1'b0, r[4:0]} + {5'h00, (pn ? r[7] : r[6])};
  endfunction

  // Expected line count, V and F per taken line strobe
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exp_v <= 1'b0;
      exp_f <= 1'b0;
      exp_p <= 1'b0;
      exp_cnt <= 6'h00;
    end else if (ce && line_strobe) begin
      nl = counter_rollover ? 6'h00 : (exp_cnt == 6'h3f ? exp_cnt : exp_cnt + 6'h01);
      pn = counter_rollover ? exp_f : exp_p;
      exp_p <= pn;
      exp_cnt <= nl;
      if (nl == eff(2)) exp_f <= ~exp_f;
      if (nl == eff(1)) exp_v <= 1'b0;
      else if (nl == eff(0)) exp_v <= 1'b1;
    end
  end
  always @(negedge core_clk) begin
    if (!sys_rst) begin
      chk_bit("vblank_bit", exp_v, vblank_bit);
      chk_bit("field_bit", exp_f, field_bit);
      chk_byte("line_counter", {2'b00, exp_cnt}, {2'b00, internal_line_counter});
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    $display("CHECK FAILED watchdog expected end seen timeout");
    finish_test();
  end
  initial begin
    errors = 0;
    compares = 0;
    sys_rst = 1'b1;
    ce = 1'b1;
    run = 1'b0;
    pal_mode = 1'b0;
    reg_req = '0;
    defs = '{bvf_pkg::RST_NTSC_VBEG, bvf_pkg::RST_NTSC_VEND, bvf_pkg::RST_NTSC_FTOG,
             bvf_pkg::RST_PAL_VBEG, bvf_pkg::RST_PAL_VEND, bvf_pkg::RST_PAL_FTOG};
    regs = defs;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++) rd(8'he5 + 8'(i), defs[i]);
    wr(8'heb, 8'h5a);
    rd(8'heb, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      pal_mode = m[0];
      for (int k = 0; k < 3; k++) begin
        dly = (k == 0) ? 8'h00 : (k == 1 ? 8'h40 : 8'h80);
        for (int s = 0; s < 3; s++) wr(8'he5 + 8'(3 * m + s), defs[3 * m + s] | dly);
        rd(8'he6 + 8'(3 * m), defs[3 * m + 1] | dly);
        run_lines(60);
        $display("test mode %0d delay %0d done", m, k);
      end
    end
    run = 1'b1;
    repeat (20) @(negedge core_clk);
    ce = 1'b0;
    wr(8'hea, 8'h00);
    repeat (10) @(negedge core_clk);
    ce = 1'b1;
    rd(8'hea, regs[5]);
    run_lines(30);
    $display("test clock enable done");
    finish_test();
  end
endmodule
